// *** shared/qustat_pkg.sv ***
// qustat_pkg: shared constants and types for the quad uart host status pins
// assumes both ends and the interface are compiled after this package
package qustat_pkg;
  localparam int          NUM_CHAN      = 4;
  localparam int          ADDR_W        = 5;
  localparam int          DATA_W        = 8;
  localparam int          CHAN_SEL_LSB  = 3;
  localparam int          CHAN_SEL_W    = 2;
  localparam int          MODEM_INT_EN_BIT    = 3;
  localparam int          MODEM_MUSIC_SEL_BIT = 5;
  localparam int          MODEM_IR_SEL_BIT    = 6;
  localparam int          REG_INT_ENABLE = 1;
  localparam int          REG_ISR       = 2;
  localparam int          REG_MODEM_CTRL = 4;
  localparam int          REG_LSR       = 5;
  localparam int          LSR_RX_AVAIL_BIT = 0;
  localparam int          REGS_PER_CHAN = 8;
  localparam logic [7:0]  REG_RESET_VAL = 8'h00;
  localparam logic [7:0]  ISR_NONE_VAL  = 8'h01;
  localparam logic [7:0]  FIFO_DEPTH    = 8'h80;
  localparam logic [3:0]  FRAME_BITS    = 4'hB;
  localparam logic [7:0]  BIT_DIV       = 8'h10;

  typedef enum logic {QUSTAT_MODE_STD, QUSTAT_MODE_ALT} qustat_mode_t;
  typedef enum {QUSTAT_H_IDLE, QUSTAT_H_SETUP, QUSTAT_H_STROBE, QUSTAT_H_DONE} qustat_hstate_t;
endpackage

// *** shared/qustat_if.sv ***
// qustat_if: host bus and status pins between the uart status end and the host end
// assumes the testbench resolves the data bus from the two enables
`timescale 1ns/1ns
interface qustat_if;
  import qustat_pkg::*;
  logic                 cs_n;
  logic [ADDR_W-1:0]    addr;
  logic                 rw_strobe;
  logic [DATA_W-1:0]    d_host;
  logic                 d_host_oe;
  logic [DATA_W-1:0]    d_dev;
  logic                 d_dev_oe;
  logic                 shared_irq_n;
  logic                 combined_rx_ready_n;
  logic                 combined_tx_ready_n;
  logic [NUM_CHAN-1:0]  per_chan_rx_ready_n;
  logic [NUM_CHAN-1:0]  per_chan_tx_ready_n;

  modport dev  (input cs_n, addr, rw_strobe, d_host, d_host_oe,
                output d_dev, d_dev_oe, shared_irq_n, combined_rx_ready_n,
                combined_tx_ready_n, per_chan_rx_ready_n, per_chan_tx_ready_n);
  modport host (output cs_n, addr, rw_strobe, d_host, d_host_oe,
                input d_dev, d_dev_oe, shared_irq_n, combined_rx_ready_n,
                combined_tx_ready_n, per_chan_rx_ready_n, per_chan_tx_ready_n);
endinterface

// *** core/qustat_dev.sv ***
// qustat_dev: status, interrupt, strobe and infrared pin logic of a four-channel uart
// assumes channel fifo state and irq conditions are supplied by the datapath
// Function
// - alt mode merges all channel irqs onto one
// - alt mode: shared request low when enabled source pending
// - host finds source by reading channel status
// - standard mode: shared pin is channel a irq
// - per-channel infrared output sends framed serial data
// - infrared output low in reset, idle, disabled
// - modem control bit 6 picks infrared interface
// - music clock drives serial ports as midi
// - standard mode: high reset clears registers, outputs
// - reset disables transmitter, ignores receiver input
// - alt mode reset is active low
// - alt mode strobe fall writes selected register
// - alt mode strobe rise drives selected register
// - combined rx ready low if any data
// - combined rx ready high when none remain
// - per-channel rx ready follows unread data, trigger
// - combined tx ready high only all full
// - host reads channel status via address decode
// - standard mode irq needs modem control bit 3
// - per-channel tx ready low while space free
`timescale 1ns/1ns
module qustat_dev
  import qustat_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  qustat_if.dev                      bus,
  input  wire qustat_pkg::qustat_mode_t mode,
  input  wire logic                  reset_pin,
  input  wire logic                  music_clock_in,
  input  wire logic [NUM_CHAN-1:0]   chan_int_cond,
  input  wire logic [NUM_CHAN*8-1:0] rx_count,
  input  wire logic [NUM_CHAN*8-1:0] rx_trigger,
  input  wire logic [NUM_CHAN*8-1:0] tx_count,
  input  wire logic [NUM_CHAN-1:0]   fifo_en,
  input  wire logic [NUM_CHAN-1:0]   tx_enable,
  input  wire logic [NUM_CHAN-1:0]   tx_load,
  input  wire logic [NUM_CHAN*8-1:0] tx_data,
  input  wire logic [NUM_CHAN-1:0]   serial_rx_port,
  output logic [NUM_CHAN-1:0]        serial_tx_port,
  output logic [NUM_CHAN-1:0]        infrared_tx_out,
  output logic [NUM_CHAN-1:0]        chan_int_out,
  output logic [NUM_CHAN-1:0]        rx_sampled,
  output logic                       dev_in_reset
);
  import qustat_pkg::*;

  // ----------------------------------------------------------------
  // reset qualification
  // ----------------------------------------------------------------
  logic pin_reset;
  logic in_rst;
  assign pin_reset = (mode == QUSTAT_MODE_STD) ? reset_pin
                                               : !reset_pin;
  assign in_rst    = !rst_n || pin_reset;

  // ----------------------------------------------------------------
  // register file, eight per channel
  // ----------------------------------------------------------------
  logic [7:0] regs_r [NUM_CHAN*REGS_PER_CHAN];
  logic       strobe_d_r;
  logic [7:0] rd_data_r;
  logic       rd_oe_r;
  logic       fall;
  logic       rise;
  logic [4:0] idx;
  assign fall = strobe_d_r && !bus.rw_strobe;
  assign rise = !strobe_d_r && bus.rw_strobe;
  assign idx  = bus.addr;

  always_ff @(posedge clk) begin
    if (in_rst) strobe_d_r <= 1'b1;
    else strobe_d_r <= bus.rw_strobe;
  end

  always_ff @(posedge clk) begin
    if (in_rst) begin
      for (int i = 0; i < NUM_CHAN*REGS_PER_CHAN; i++) regs_r[i] <= REG_RESET_VAL;
    end else if (mode == QUSTAT_MODE_ALT && fall && !bus.cs_n && bus.d_host_oe) begin
      regs_r[idx] <= bus.d_host;
    end
  end

  // status registers are computed live so the host can poll them
  logic [CHAN_SEL_W-1:0] sel_ch;
  logic [2:0]            sel_reg;
  logic [7:0]            rd_val;
  logic [NUM_CHAN-1:0]   rx_avail;
  logic [NUM_CHAN-1:0]   src_pend;
  assign sel_ch  = idx[CHAN_SEL_LSB +: CHAN_SEL_W];
  assign sel_reg = idx[2:0];
  always_comb begin
    rd_val = regs_r[idx];
    if (sel_reg == 3'(REG_ISR))
      rd_val = src_pend[sel_ch] ? 8'h00 : ISR_NONE_VAL;
    else if (sel_reg == 3'(REG_LSR)) begin
      rd_val = 8'h00;
      rd_val[LSR_RX_AVAIL_BIT] = rx_avail[sel_ch];
    end
  end

  always_ff @(posedge clk) begin
    if (in_rst) begin
      rd_data_r <= 8'h00;
      rd_oe_r   <= 1'b0;
    end else if (mode == QUSTAT_MODE_ALT && rise && !bus.cs_n) begin
      rd_data_r <= rd_val;
      rd_oe_r   <= 1'b1;
    end else if (bus.cs_n || fall) begin
      rd_oe_r   <= 1'b0;
    end
  end
  assign bus.d_dev    = rd_data_r;
  assign bus.d_dev_oe = rd_oe_r;

  // ----------------------------------------------------------------
  // per-channel status and interrupt logic
  // ----------------------------------------------------------------
  logic [NUM_CHAN-1:0] rx_rdy_n_r;
  logic [NUM_CHAN-1:0] tx_rdy_n_r;
  logic [NUM_CHAN-1:0] int_out_r;
  logic [NUM_CHAN-1:0] tx_full;
  logic [NUM_CHAN-1:0] ir_sel;
  logic                irq_n_r;
  logic                crx_n_r;
  logic                ctx_n_r;

  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : g_ch
      logic [7:0] rx_cnt;
      logic [7:0] tx_cnt;
      logic [7:0] cap;
      logic [7:0] trg;
      assign rx_cnt = rx_count[g*8 +: 8];
      assign tx_cnt = tx_count[g*8 +: 8];
      assign cap = fifo_en[g] ? FIFO_DEPTH : 8'h01;
      assign trg = fifo_en[g] ? rx_trigger[g*8 +: 8] : 8'h01;
      assign rx_avail[g] = (rx_cnt != 8'h00);
      assign tx_full[g]  = (tx_cnt >= cap);
      assign src_pend[g] = chan_int_cond[g]
                        && (regs_r[g*REGS_PER_CHAN+REG_INT_ENABLE] != 8'h00);
      assign ir_sel[g]   = regs_r[g*REGS_PER_CHAN+REG_MODEM_CTRL][MODEM_IR_SEL_BIT];

      always_ff @(posedge clk) begin
        if (in_rst) begin
          rx_rdy_n_r[g] <= 1'b1;
          tx_rdy_n_r[g] <= 1'b1;
          int_out_r[g]  <= 1'b0;
        end else begin
          rx_rdy_n_r[g] <= !(rx_avail[g] && rx_cnt >= trg);
          tx_rdy_n_r[g] <= tx_full[g];
          int_out_r[g]  <= src_pend[g]
                        && regs_r[g*REGS_PER_CHAN+REG_MODEM_CTRL][MODEM_INT_EN_BIT];
        end
      end

      // frame shifter: start, eight data, parity, stop
      logic [10:0] sh_r;
      logic [3:0]  bits_r;
      logic [7:0]  div_r;
      logic        tick;
      logic        bit_clk_d_r;
      logic        bit_clk_s_r;
      logic        music_sel;
      assign music_sel = regs_r[g*REGS_PER_CHAN+REG_MODEM_CTRL][MODEM_MUSIC_SEL_BIT];
      // music clock edges pace bits when selected, otherwise the divider
      assign tick = music_sel ? (bit_clk_s_r && !bit_clk_d_r) : (div_r == 8'h00);
      always_ff @(posedge clk) begin
        if (in_rst) begin
          bit_clk_s_r <= 1'b0;
          bit_clk_d_r <= 1'b0;
          div_r       <= BIT_DIV - 8'h01;
        end else begin
          bit_clk_s_r <= music_clock_in;
          bit_clk_d_r <= bit_clk_s_r;
          // held at full count while idle, so the start bit is never cut short
          div_r       <= (div_r == 8'h00 || bits_r == 4'h0) ? BIT_DIV - 8'h01
                                                           : div_r - 8'h01;
        end
      end
      always_ff @(posedge clk) begin
        if (in_rst || !tx_enable[g]) begin
          bits_r <= 4'h0;
          sh_r   <= 11'h7FF;
        end else if (bits_r == 4'h0 && tx_load[g]) begin
          sh_r   <= {1'b1, ^tx_data[g*8 +: 8], tx_data[g*8 +: 8], 1'b0};
          bits_r <= FRAME_BITS;
        end else if (bits_r != 4'h0 && tick) begin
          sh_r   <= {1'b1, sh_r[10:1]};
          bits_r <= bits_r - 4'h1;
        end
      end
      always_ff @(posedge clk) begin
        if (in_rst) begin
          serial_tx_port[g]  <= 1'b1;
          infrared_tx_out[g] <= 1'b0;
          rx_sampled[g]      <= 1'b1;
        end else begin
          serial_tx_port[g]  <= (ir_sel[g] || bits_r == 4'h0) ? 1'b1 : sh_r[0];
          // infrared pulses mark a zero bit; idle or disabled stays low
          infrared_tx_out[g] <= ir_sel[g] && bits_r != 4'h0 && !sh_r[0];
          rx_sampled[g]      <= serial_rx_port[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // combined pins
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (in_rst) begin
      irq_n_r      <= 1'b1;
      crx_n_r      <= 1'b1;
      ctx_n_r      <= 1'b1;
      dev_in_reset <= 1'b1;
    end else begin
      if (mode == QUSTAT_MODE_ALT) irq_n_r <= !(|src_pend);
      else irq_n_r <= !int_out_r[0];
      crx_n_r      <= !(|rx_avail);
      ctx_n_r      <= &tx_full;
      dev_in_reset <= 1'b0;
    end
  end
  assign bus.shared_irq_n        = irq_n_r;
  assign bus.combined_rx_ready_n = crx_n_r;
  assign bus.combined_tx_ready_n = ctx_n_r;
  assign bus.per_chan_rx_ready_n = rx_rdy_n_r;
  assign bus.per_chan_tx_ready_n = tx_rdy_n_r;
  assign chan_int_out            = int_out_r;
endmodule

// *** core/qustat_host.sv ***
// qustat_host: host bus master that writes and reads device registers with one strobe
// assumes the device samples the strobe on the same clock
// Function (see device file for the full list)
`timescale 1ns/1ns
module qustat_host
  import qustat_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  qustat_if.host                 bus,
  input  wire logic              req,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  output logic                   busy,
  output logic                   done,
  output logic [DATA_W-1:0]      rdata,
  output logic                   irq_seen
);
  import qustat_pkg::*;

  qustat_hstate_t st_r;
  logic           wr_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wd_r;
  logic           cs_n_r;
  logic           strobe_r;
  logic           oe_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= QUSTAT_H_IDLE;
      wr_r <= 1'b0;
      addr_r <= '0;
      wd_r <= '0;
      cs_n_r <= 1'b1;
      strobe_r <= 1'b1;
      oe_r <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      rdata <= '0;
    end else begin
      done <= 1'b0;
      case (st_r)
        QUSTAT_H_IDLE: begin
          if (req) begin
            wr_r <= req_write;
            addr_r <= req_addr;
            wd_r <= req_wdata;
            cs_n_r <= 1'b0;
            oe_r <= req_write;
            // a read rises from low, so park the strobe low first
            strobe_r <= req_write;
            busy <= 1'b1;
            st_r <= QUSTAT_H_SETUP;
          end
        end
        QUSTAT_H_SETUP: begin
          strobe_r <= !wr_r;
          st_r <= QUSTAT_H_STROBE;
        end
        QUSTAT_H_STROBE: begin
          st_r <= QUSTAT_H_DONE;
        end
        QUSTAT_H_DONE: begin
          if (!wr_r) rdata <= bus.d_dev;
          cs_n_r <= 1'b1;
          strobe_r <= 1'b1;
          oe_r <= 1'b0;
          busy <= 1'b0;
          done <= 1'b1;
          st_r <= QUSTAT_H_IDLE;
        end
        default: st_r <= QUSTAT_H_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) irq_seen <= 1'b0;
    else irq_seen <= !bus.shared_irq_n;
  end

  assign bus.cs_n      = cs_n_r;
  assign bus.addr      = addr_r;
  assign bus.rw_strobe = strobe_r;
  assign bus.d_host    = wd_r;
  assign bus.d_host_oe = oe_r;
endmodule

// *** verification/qustat_props.sv ***
// qustat_props: pin assertions beside the interface joining both ends
// assumes one clock domain and the design's synchronous rst_n
`timescale 1ns/1ns
module qustat_props
  import qustat_pkg::*;
(
  input wire logic                      clk,
  input wire logic                      rst_n,
  input wire qustat_pkg::qustat_mode_t  mode,
  input wire logic                      reset_pin,
  input wire logic [NUM_CHAN*8-1:0]     rx_count,
  input wire logic [NUM_CHAN*8-1:0]     tx_count,
  input wire logic [NUM_CHAN-1:0]       fifo_en,
  input wire logic                      cs_n,
  input wire logic                      rw_strobe,
  input wire logic                      d_host_oe,
  input wire logic                      d_dev_oe,
  input wire logic                      shared_irq_n,
  input wire logic                      combined_rx_ready_n,
  input wire logic                      combined_tx_ready_n,
  input wire logic [NUM_CHAN-1:0]       per_chan_rx_ready_n,
  input wire logic [NUM_CHAN-1:0]       per_chan_tx_ready_n,
  input wire logic [NUM_CHAN-1:0]       infrared_tx_out,
  input wire logic [NUM_CHAN-1:0]       serial_tx_port,
  input wire logic [NUM_CHAN-1:0]       chan_int_out,
  input wire logic                      dev_in_reset
);
  logic [NUM_CHAN-1:0] tx_full_c;
  // ---------------------------------------------------------------
  // helper and properties
  // ---------------------------------------------------------------
  // a disabled fifo leaves a one-entry holding register
  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      tx_full_c[i] = tx_count[i*8+:8] >= (fifo_en[i] ? FIFO_DEPTH : 8'h01);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_pin_reset;
    (mode == QUSTAT_MODE_STD) == reset_pin |=> shared_irq_n && combined_rx_ready_n
      && combined_tx_ready_n && &per_chan_rx_ready_n && &per_chan_tx_ready_n && !d_dev_oe;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pins not at reset level");
  property p_reset_lines;
    dev_in_reset |-> infrared_tx_out == 4'h0 && &serial_tx_port && chan_int_out == 4'h0;
  endproperty
  a_reset_lines: assert property (p_reset_lines) else $error("serial lines active in reset");
  property p_tx_ready;
    !dev_in_reset |-> per_chan_tx_ready_n == $past(tx_full_c)
      && combined_tx_ready_n == &$past(tx_full_c);
  endproperty
  a_tx_ready: assert property (p_tx_ready) else $error("tx ready pins wrong");
  property p_rx_comb;
    !dev_in_reset |-> combined_rx_ready_n == ($past(rx_count) == 32'h0);
  endproperty
  a_rx_comb: assert property (p_rx_comb) else $error("combined rx ready wrong");
  property p_rd_answer;
    mode == QUSTAT_MODE_ALT && reset_pin && $rose(rw_strobe) && !cs_n |=> d_dev_oe;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read data not driven");
  property p_wr_release;
    $fell(rw_strobe) && !cs_n |=> !d_dev_oe;
  endproperty
  a_wr_release: assert property (p_wr_release) else $error("device drives during write");
  property p_cs_idle;
    cs_n [*2] |-> !d_dev_oe;
  endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("device drives while deselected");
  property p_std_quiet;
    (mode == QUSTAT_MODE_STD) [*3] |-> !d_dev_oe;
  endproperty
  a_std_quiet: assert property (p_std_quiet) else $error("bus answered in standard mode");
  property p_irq_std;
    (mode == QUSTAT_MODE_STD && !dev_in_reset) [*2] |-> shared_irq_n == !$past(chan_int_out[0]);
  endproperty
  a_irq_std: assert property (p_irq_std) else $error("shared pin not channel a");
  c_write: cover property ($fell(rw_strobe) && !cs_n && d_host_oe);
  c_read: cover property (d_dev_oe);
  c_all_full: cover property (!dev_in_reset && combined_tx_ready_n);
  c_irq: cover property (mode == QUSTAT_MODE_ALT && !shared_irq_n);
endmodule

// *** verification/quad_uart_host_status_pins_tb.sv ***
// quad_uart_host_status_pins_tb: both ends joined, status pins and host accesses checked
// assumes package, interface, both ends and qustat_props are compiled first
`timescale 1ns/1ns
module quad_uart_host_status_pins_tb;
  import qustat_pkg::*;
  typedef struct {
    logic [31:0] rcnt, rxt, tcnt;
    logic [3:0]  fen, prx, ptx;
    logic        crx, ctx;
  } qustat_row_t;
  qustat_row_t rows [5] = '{
    '{32'h0, 32'h01010101, 32'h0, 4'hF, 4'hF, 4'h0, 1'b1, 1'b0},
    '{32'h00000003, 32'h01010104, 32'h80808080, 4'hF, 4'hF, 4'hF, 1'b0, 1'b1},
    '{32'h00000400, 32'h01010404, 32'h7F808080, 4'hF, 4'hD, 4'h7, 1'b0, 1'b0},
    '{32'h00000001, 32'h01010110, 32'h80808001, 4'hE, 4'hE, 4'hF, 1'b0, 1'b1},
    '{32'h02000000, 32'h40010101, 32'h00010001, 4'h0, 4'h7, 4'h5, 1'b0, 1'b0}};
  logic clk = 1'b0, rst_n = 1'b0, reset_pin = 1'b1, music_clock_in = 1'b0;
  logic req = 1'b0, req_write = 1'b0, busy, done, irq_seen, dev_in_reset;
  qustat_mode_t mode = QUSTAT_MODE_ALT;
  logic [3:0] chan_int_cond = 4'h0, fifo_en = 4'hF, tx_enable = 4'hF, tx_load = 4'h0;
  logic [3:0] serial_rx_port = 4'hF, serial_tx_port, infrared_tx_out, chan_int_out, rx_sampled;
  logic [31:0] rx_count = 32'h0, rx_trigger = 32'h0, tx_count = 32'h0, tx_data = 32'h0;
  logic [4:0] req_addr = 5'h00;
  logic [7:0] req_wdata = 8'h00, rdata;
  logic [10:0] frame;
  int error_cnt = 0, check_count = 0, n;
  qustat_if bus_if ();
  qustat_dev i_qustat_dev (.clk, .rst_n, .bus(bus_if), .mode, .reset_pin, .music_clock_in,
    .chan_int_cond, .rx_count, .rx_trigger, .tx_count, .fifo_en, .tx_enable, .tx_load,
    .tx_data, .serial_rx_port, .serial_tx_port, .infrared_tx_out, .chan_int_out, .rx_sampled,
    .dev_in_reset);
  qustat_host i_qustat_host (.clk, .rst_n, .bus(bus_if), .req, .req_write, .req_addr,
    .req_wdata, .busy, .done, .rdata, .irq_seen);
  qustat_props i_qustat_props (.clk, .rst_n, .mode, .reset_pin, .rx_count, .tx_count,
    .fifo_en, .cs_n(bus_if.cs_n), .rw_strobe(bus_if.rw_strobe), .d_host_oe(bus_if.d_host_oe),
    .d_dev_oe(bus_if.d_dev_oe), .shared_irq_n(bus_if.shared_irq_n),
    .combined_rx_ready_n(bus_if.combined_rx_ready_n),
    .combined_tx_ready_n(bus_if.combined_tx_ready_n),
    .per_chan_rx_ready_n(bus_if.per_chan_rx_ready_n),
    .per_chan_tx_ready_n(bus_if.per_chan_tx_ready_n), .infrared_tx_out, .serial_tx_port,
    .chan_int_out, .dev_in_reset);
  always #50 clk = ~clk;
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic results();
    if (error_cnt == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // entered at a falling edge; one idle cycle after done keeps requests apart
  task automatic host_op(input logic wr, input logic [4:0] a, input logic [7:0] wd);
    req = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = wd;
    @(negedge clk);
    req = 1'b0;
    for (n = 0; n < 20 && done !== 1'b1; n++) @(negedge clk);
    if (n == 20) begin
      chk(0, 1, "host timeout");
      results();
    end
    chk(busy, 1'b0, "busy after done");
    @(negedge clk);
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      rx_count = rows[i].rcnt;
      rx_trigger = rows[i].rxt;
      tx_count = rows[i].tcnt;
      fifo_en = rows[i].fen;
      @(negedge clk);
      chk({bus_if.per_chan_rx_ready_n, bus_if.per_chan_tx_ready_n, bus_if.combined_rx_ready_n,
           bus_if.combined_tx_ready_n}, {rows[i].prx, rows[i].ptx, rows[i].crx, rows[i].ctx},
          "ready pins");
    end
    host_op(1'b1, 5'h11, 8'h01);
    chan_int_cond = 4'b0001;
    repeat (2) @(negedge clk);
    chk(bus_if.shared_irq_n, 1'b1, "irq without enable");
    chan_int_cond = 4'b0101;
    repeat (2) @(negedge clk);
    chk({bus_if.shared_irq_n, irq_seen}, 2'b01, "merged irq");
    host_op(1'b0, 5'h12, 8'h00);
    chk(rdata, 8'h00, "pending status");
    host_op(1'b0, 5'h0A, 8'h00);
    chk(rdata, ISR_NONE_VAL, "idle status");
    host_op(1'b0, 5'h1D, 8'h00);
    chk(rdata, 8'h01 << LSR_RX_AVAIL_BIT, "rx status");
    host_op(1'b0, 5'h05, 8'h00);
    chk(rdata, 8'h00, "rx status empty");
    host_op(1'b1, 5'h1C, 8'h48);
    host_op(1'b0, 5'h1C, 8'h00);
    chk(rdata, 8'h48, "readback");
    host_op(1'b1, 5'h01, 8'h01);
    host_op(1'b1, 5'h04, 8'h08);
    mode = QUSTAT_MODE_STD;
    reset_pin = 1'b0;
    repeat (3) @(negedge clk);
    chk({chan_int_out, bus_if.shared_irq_n}, 5'b00010, "standard irq");
    reset_pin = 1'b1;
    serial_rx_port = 4'h0;
    repeat (2) @(negedge clk);
    chk({dev_in_reset, rx_sampled, serial_tx_port, infrared_tx_out}, 13'h1FF0, "reset");
    mode = QUSTAT_MODE_ALT;
    serial_rx_port = 4'hF;
    @(negedge clk);
    host_op(1'b0, 5'h1C, 8'h00);
    chk(rdata, REG_RESET_VAL, "cleared");
    reset_pin = 1'b0;
    repeat (2) @(negedge clk);
    chk(dev_in_reset, 1'b1, "low reset");
    reset_pin = 1'b1;
    @(negedge clk);
    host_op(1'b1, 5'h0C, 8'h40);
    tx_data = 32'h000000A5;
    tx_load = 4'b0011;
    @(negedge clk);
    tx_load = 4'h0;
    for (n = 0; n < 40 && serial_tx_port[0] !== 1'b0; n++) @(negedge clk);
    if (n == 40) begin
      chk(0, 1, "start timeout");
      results();
    end
    chk(infrared_tx_out, 4'b0010, "infrared start");
    repeat (8) @(negedge clk);
    // sample each bit near its middle
    for (int b = 0; b < 11; b++) begin
      frame[b] = serial_tx_port[0];
      repeat (16) @(negedge clk);
    end
    chk(frame, 11'h54A, "frame");
    chk(infrared_tx_out, 4'h0, "infrared idle");
    tx_load = 4'b0010;
    @(negedge clk);
    tx_load = 4'h0;
    @(negedge clk);
    chk(infrared_tx_out, 4'b0010, "infrared restart");
    tx_enable = 4'hD;
    repeat (2) @(negedge clk);
    chk(infrared_tx_out, 4'h0, "infrared disabled");
    // music clock pacing on channel 0: no bit moves without its edge
    host_op(1'b1, 5'h04, 8'h20);
    tx_load = 4'b0001;
    @(negedge clk);
    tx_load = 4'h0;
    repeat (20) @(negedge clk);
    chk(serial_tx_port[0], 1'b0, "held start");
    music_clock_in = 1'b1;
    repeat (4) @(negedge clk);
    chk(serial_tx_port[0], 1'b1, "paced bit");
    music_clock_in = 1'b0;
    results();
  end
endmodule
